// *** pbc_pkg.sv ***
package pbc_pkg;

  localparam logic [11:0] OFF_HEADER    = 12'h280;
  localparam logic [11:0] OFF_SELECT    = 12'h284;
  localparam logic [11:0] OFF_WINDOW    = 12'h288;
  localparam logic [11:0] OFF_FLAGS     = 12'h28C;
  localparam logic [11:0] OFF_SYSTEM_CONTROL_REGISTER    = 12'h290;
  localparam logic [11:0] OFF_WORD_BASE = 12'h300;

  localparam int          WORD_COUNT    = 8;
  localparam logic [7:0]  SEL_MAX       = 8'h07;

  // Values the initialisation path is expected to load
  localparam logic [15:0] CAP_ID_POWER_BUDGET = 16'h0004;
  localparam logic [3:0]  CAP_VERSION_ONE     = 4'h1;

  localparam logic [31:0] RST_HEADER    = 32'h0000_0000;
  localparam logic [7:0]  RST_SELECT    = 8'h00;
  localparam logic        RST_SA        = 1'b0;
  localparam logic        RST_UNLOCK    = 1'b0;
  localparam logic [31:0] RST_RDATA     = 32'h0000_0000;

  localparam int          SEL_LSB       = 0;
  localparam int          SA_BIT        = 0;
  localparam int          UNLOCK_BIT    = 0;

  localparam logic [2:0]  HSIZE_WORD    = 3'b010;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } pbc_state_t;

  typedef struct packed {
    logic [11:0] next;
    logic [3:0]  version;
    logic [15:0] ident;
  } pbc_header_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic        wordSize;
  } pbc_req_t;

endpackage

// *** pbc_regs.sv ***
// Function
// - Identifier in header bits 15:0, resets zero
// - Version in header bits 19:16, resets zero
// - Eight-bit selector picks window word, resets zero
// - Selector above seven makes window read zero
// - Window read-only, returns selected stored word
// - Flag bit zero marks budget already allocated
// - Stored words at 0x300, sticky, no reset
// - Stored words writable only while unlock set
module pbc_regs (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        initActive,
  output logic             systemAllocated
);

  function automatic logic isDataWord(input logic [11:0] a);
    isDataWord = (a[11:5] == pbc_pkg::OFF_WORD_BASE[11:5]) &&
                 (a[1:0] == 2'b00);
  endfunction

  function automatic logic [2:0] wordIndex(input logic [11:0] a);
    wordIndex = a[4:2];
  endfunction

  pbc_pkg::pbc_state_t  state_reg;
  pbc_pkg::pbc_state_t  state_next;
  pbc_pkg::pbc_req_t    req_reg;
  pbc_pkg::pbc_req_t    req_next;
  pbc_pkg::pbc_header_t header_reg;
  logic [7:0]           sel_reg;
  logic                 sa_reg;
  logic                 unlock_reg;
  logic [31:0]          rdata_reg;
  logic [31:0]          rdata_next;
  localparam int WORDS_TOP = pbc_pkg::WORD_COUNT - 1;

  logic                 ready_reg;
  logic [31:0]          words [WORDS_TOP:0];

  wire accept = hsel && htrans[1] && hready &&
                (state_reg == pbc_pkg::ST_IDLE);
  wire inWait = (state_reg == pbc_pkg::ST_WAIT);
  wire doWrite = inWait && req_reg.write && req_reg.wordSize;
  wire doRead = inWait && !req_reg.write;

  wire hitHeader = (req_reg.addr == pbc_pkg::OFF_HEADER);
  wire hitSelect = (req_reg.addr == pbc_pkg::OFF_SELECT);
  wire hitWindow = (req_reg.addr == pbc_pkg::OFF_WINDOW);
  wire hitFlags  = (req_reg.addr == pbc_pkg::OFF_FLAGS);
  wire hitSysctl = (req_reg.addr == pbc_pkg::OFF_SYSTEM_CONTROL_REGISTER);
  wire hitWord   = isDataWord(req_reg.addr);

  // Lockable fields open only to the initialisation loader
  wire lockOpen = initActive;

  wire wrHeader = doWrite && hitHeader && lockOpen;
  wire wrFlags  = doWrite && hitFlags && lockOpen;
  wire wrSelect = doWrite && hitSelect;
  wire wrSysctl = doWrite && hitSysctl;
  wire wrWord   = doWrite && hitWord && unlock_reg;
  wire sa_next_out = wrFlags ? hwdata[pbc_pkg::SA_BIT] : sa_reg;

  wire selInRange = (sel_reg <= pbc_pkg::SEL_MAX);
  wire [31:0] windowValue =
    selInRange ? words[sel_reg[2:0]] : 32'h0000_0000;

  wire [31:0] selectValue = {24'h00_0000, sel_reg};
  wire [31:0] flagsValue  = {31'h0000_0000, sa_reg};
  wire [31:0] sysctlValue = {31'h0000_0000, unlock_reg};
  wire [31:0] wordValue   = words[wordIndex(req_reg.addr)];

  wire [31:0] readMux =
    hitHeader ? header_reg :
    hitSelect ? selectValue :
    hitWindow ? windowValue :
    hitFlags  ? flagsValue :
    hitSysctl ? sysctlValue :
    hitWord   ? wordValue :
    32'h0000_0000;

  // One wait state per transfer so a read never races the previous write
  assign state_next = accept ? pbc_pkg::ST_WAIT :
                      inWait ? pbc_pkg::ST_IDLE : state_reg;
  assign req_next   = accept ? pbc_pkg::pbc_req_t'{
                                 addr:     haddr[11:0],
                                 write:    hwrite,
                                 wordSize: (hsize == pbc_pkg::HSIZE_WORD)}
                             : req_reg;
  assign rdata_next = doRead ? readMux : rdata_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= pbc_pkg::ST_IDLE;
      req_reg   <= '0;
      ready_reg <= 1'b1;
      rdata_reg <= pbc_pkg::RST_RDATA;
    end else begin
      state_reg <= state_next;
      req_reg   <= req_next;
      ready_reg <= !accept;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      header_reg <= pbc_pkg::RST_HEADER;
    end else if (wrHeader) begin
      header_reg <= hwdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_reg <= pbc_pkg::RST_SELECT;
    end else if (wrSelect) begin
      sel_reg <= hwdata[pbc_pkg::SEL_LSB +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sa_reg <= pbc_pkg::RST_SA;
    end else if (wrFlags) begin
      sa_reg <= hwdata[pbc_pkg::SA_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      unlock_reg <= pbc_pkg::RST_UNLOCK;
    end else if (wrSysctl) begin
      unlock_reg <= hwdata[pbc_pkg::UNLOCK_BIT];
    end
  end

  // Sticky store: deliberately outside srst so contents survive reset
  always_ff @(posedge clk) begin
    if (wrWord) begin
      words[wordIndex(req_reg.addr)] <= hwdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      systemAllocated <= pbc_pkg::RST_SA;
    end else begin
      systemAllocated <= sa_next_out;
    end
  end

  assign hrdata    = rdata_reg;
  assign hreadyout = ready_reg;

  always_ff @(posedge clk) begin
    hresp <= 1'b0;
  end

endmodule

// *** pbc_regs_fix.sv ***
// (intentionally empty)

// *** pbc_regs_sva.sv ***
module pbc_regs_sva (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        initActive,
  input wire logic        systemAllocated
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire taken = hsel && htrans[1] && hready && hreadyout;
  a_one_wait: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  a_short_wait: assert property (!hreadyout |=> hreadyout)
    else $error("hreadyout low too long");
  a_idle_ready: assert property (!taken && hreadyout |=> hreadyout)
    else $error("wait state without request");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_rdata_holds: assert property (hreadyout |=> $stable(hrdata))
    else $error("read data moved while idle");
  a_reset_bus: assert property ($fell(srst) |-> hreadyout && hrdata == 0)
    else $error("bus outputs not reset");
  a_reset_flag: assert property ($fell(srst) |-> !systemAllocated)
    else $error("flag not reset");
  a_flag_locked: assert property ($changed(systemAllocated) && !$past(srst)
    |-> $past(initActive) && !$past(hreadyout))
    else $error("flag changed outside initialisation write");
endmodule
bind pbc_regs pbc_regs_sva pbc_regs_sva_i (.*);

// *** pbc_regs_tb.sv ***
module pbc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, srst = 1, hsel = 0, hwrite = 0, initActive = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, systemAllocated;
  wire         hready = hreadyout;
  int          num_errors = 0, num_checks = 0;
  typedef struct { logic w; logic [11:0] a; logic [31:0] d, e; } pbc_row_t;
  pbc_row_t rows [11] = '{'{0, 12'h280, 0, 0}, '{0, 12'h284, 0, 0},
    '{0, 12'h28C, 0, 0}, '{1, 12'h280, 32'h0001_0004, 0},
    '{0, 12'h280, 0, 32'h0001_0004}, '{1, 12'h28C, 32'hFFFF_FFFF, 0},
    '{0, 12'h28C, 0, 1}, '{1, 12'h284, 32'hFFFF_FF09, 0},
    '{0, 12'h284, 0, 9}, '{0, 12'h288, 0, 0}, '{0, 12'h2FC, 0, 0}};
  pbc_regs pbc_regs_i (.*);
  initial forever #50 clk = ~clk;
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %0t got %h want %h", $time, g, e);
      num_errors++;
    end
  endtask
  // Address phase held until taken, then data phase until hready returns
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    do @(posedge clk); while (!hready && ++n < 20);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (!hready && ++n < 20);
    r = hrdata;
    if (n >= 20) begin
      num_errors++;
      final_report;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(r, rows[i].e);
    end
    chk({31'h0, systemAllocated}, 1);
    $display("table done");
    initActive <= 0;
    xfer(1, 12'h290, 1);
    for (int i = 0; i < 8; i++) xfer(1, 12'h300 + 12'(4 * i), 32'hA5A5_0000 + i);
    for (int i = 0; i < 8; i++) begin
      xfer(1, 12'h284, i);
      xfer(0, 12'h288, 0);
      chk(r, 32'hA5A5_0000 + i);
    end
    $display("window done");
    xfer(1, 12'h290, 0);
    xfer(1, 12'h300, 0);
    xfer(1, 12'h288, 0);
    xfer(1, 12'h280, 0);
    xfer(1, 12'h28C, 0);
    xfer(0, 12'h300, 0);
    chk(r, 32'hA5A5_0000);
    xfer(0, 12'h288, 0);
    chk(r, 32'hA5A5_0007);
    xfer(0, 12'h280, 0);
    chk(r, 32'h0001_0004);
    chk({31'h0, systemAllocated}, 1);
    $display("lock done");
    srst <= 1;
    @(posedge clk);
    srst <= 0;
    xfer(0, 12'h304, 0);
    chk(r, 32'hA5A5_0001);
    chk({31'h0, systemAllocated}, 0);
    xfer(0, 12'h280, 0);
    chk(r, 0);
    hsize <= 3'h0;
    xfer(1, 12'h284, 5);
    hsize <= 3'h2;
    xfer(0, 12'h284, 0);
    chk(r, 0);
    chk({31'h0, hresp}, 0);
    $display("reset done");
    final_report;
  end
endmodule
